// File: logic/nva_access.sv
// Register-driven access controller for the nonvolatile data array, AHB-Lite slave
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module nva_access #(
  parameter int WRITE_CYCLES = nva_pkg::WRITE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        warm_reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  nva_core_if core ();

  nva_array u_array (
    .clk  (clk),
    .port (core.mem)
  );

  nva_timer #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .tc     (core.tmr)
  );

  // Bus data phase tracking
  logic        dph_r;
  logic        dph_wr_r;
  logic [7:0]  dph_ofs_r;
  logic        rd_done_r;
  logic [31:0] hrdata_r;

  // Register state
  logic        space_r;
  logic        cfg_r;
  logic        row_r;
  logic        abort_r;
  logic        permit_r;
  logic        cycle_r;
  logic        fetch_r;
  logic        fetch_load_r;
  logic        done_r;
  logic        cycle_data_r;
  logic [7:0]  index_r;
  logic [7:0]  value_r;
  nva_pkg::nva_unlock_t unlock_r;

  logic       addr_take;
  logic       wr_commit;
  logic [7:0] wdat;
  logic       ctrl_wr;
  logic       unlock_wr;
  logic       index_wr;
  logic       value_wr;
  logic       flag_wr;
  logic       launch_req;
  logic       start_ok;
  logic       start_now;
  logic       improper;
  logic       fetch_busy;
  logic       space_nxt;
  logic       cfg_nxt;
  logic [7:0] ctrl_view;

  assign addr_take = hsel && hready
                     && ((htrans == nva_pkg::HTRANS_NONSEQ) || (htrans == nva_pkg::HTRANS_SEQ));
  assign wr_commit = dph_r && dph_wr_r;
  assign wdat      = hwdata[7:0];
  assign ctrl_wr   = wr_commit && (dph_ofs_r == nva_pkg::OFS_CTRL) && !cycle_r;
  assign unlock_wr = wr_commit && (dph_ofs_r == nva_pkg::OFS_UNLOCK);
  assign index_wr  = wr_commit && (dph_ofs_r == nva_pkg::OFS_INDEX) && !cycle_r;
  assign value_wr  = wr_commit && (dph_ofs_r == nva_pkg::OFS_VALUE) && !cycle_r;
  assign flag_wr   = wr_commit && (dph_ofs_r == nva_pkg::OFS_FLAG);

  // Permit must already be stored; setting both in one write does not start a cycle
  assign launch_req = ctrl_wr && wdat[nva_pkg::B_CYCLE];
  assign start_ok   = (unlock_r == nva_pkg::UNL_ARMED) && permit_r;
  assign start_now  = launch_req && start_ok;
  assign improper   = launch_req && !start_ok;
  assign space_nxt  = wdat[nva_pkg::B_SPACE];
  assign cfg_nxt    = wdat[nva_pkg::B_CFG];
  assign fetch_busy = fetch_r || fetch_load_r;

  // Bit 5 is tied low in the readback
  assign ctrl_view = {space_r, cfg_r, 1'b0, row_r, abort_r, permit_r, cycle_r, fetch_r};

  // Array and timer hookup; only data-array cycles touch the cells
  assign core.tmr_start  = start_now;
  assign core.tmr_cancel = warm_reset;
  assign core.mem_re     = fetch_r;
  assign core.mem_addr   = index_r;
  assign core.mem_we     = cycle_data_r && (core.tmr_erase_end || core.tmr_done);
  assign core.mem_wdata  = core.tmr_done ? value_r : nva_pkg::ERASED_BYTE;

  // Reads wait one cycle for registered data and for any fetch in flight
  assign hreadyout = !dph_r || dph_wr_r || rd_done_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      dph_r     <= 1'b0;
      dph_wr_r  <= 1'b0;
      dph_ofs_r <= nva_pkg::RESET_BYTE;
    end
    else if (hreadyout)
    begin
      dph_r     <= addr_take;
      dph_wr_r  <= hwrite;
      dph_ofs_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_done_r <= 1'b0;
      hrdata_r  <= 32'h00000000;
    end
    else if (hreadyout)
    begin
      rd_done_r <= 1'b0;
    end
    else if (!fetch_busy)
    begin
      rd_done_r <= 1'b1;
      unique case (dph_ofs_r)
        nva_pkg::OFS_CTRL:   hrdata_r <= {24'h000000, ctrl_view};
        nva_pkg::OFS_INDEX:  hrdata_r <= {24'h000000, index_r};
        nva_pkg::OFS_VALUE:  hrdata_r <= {24'h000000, value_r};
        nva_pkg::OFS_FLAG:   hrdata_r <= {24'h000000, 3'h0, done_r, 4'h0};
        default:             hrdata_r <= 32'h00000000;
      endcase
    end
  end

  // Unlock sequencer: any other write breaks the chain
  always_ff @(posedge clk)
  begin
    if (!resetn || warm_reset)
    begin
      unlock_r <= nva_pkg::UNL_IDLE;
    end
    else if (wr_commit)
    begin
      if (unlock_wr && (wdat == nva_pkg::KEY_FIRST))
      begin
        unlock_r <= nva_pkg::UNL_HALF;
      end
      else if (unlock_wr && (wdat == nva_pkg::KEY_SECOND) && (unlock_r == nva_pkg::UNL_HALF))
      begin
        unlock_r <= nva_pkg::UNL_ARMED;
      end
      else
      begin
        unlock_r <= nva_pkg::UNL_IDLE;
      end
    end
  end

  // Space selects, permit and row erase
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      space_r  <= 1'b0;
      cfg_r    <= 1'b0;
      permit_r <= 1'b0;
      row_r    <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      space_r  <= space_nxt;
      cfg_r    <= cfg_nxt;
      permit_r <= wdat[nva_pkg::B_PERMIT];
      row_r    <= wdat[nva_pkg::B_ROW];
    end
    else if (core.tmr_done && row_r)
    begin
      row_r <= 1'b0;
    end
  end

  // Cycle launch and target capture; a warm reset kills the cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cycle_r      <= 1'b0;
      cycle_data_r <= 1'b0;
    end
    else if (warm_reset)
    begin
      cycle_r <= 1'b0;
    end
    else if (start_now)
    begin
      cycle_r      <= 1'b1;
      cycle_data_r <= !space_nxt && !cfg_nxt && !wdat[nva_pkg::B_ROW];
    end
    else if (core.tmr_done)
    begin
      cycle_r <= 1'b0;
    end
  end

  // Abort flag; spaces are left alone so the failed access can be traced
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      abort_r <= 1'b0;
    end
    else if (warm_reset && cycle_r)
    begin
      abort_r <= 1'b1;
    end
    else if (improper)
    begin
      abort_r <= 1'b1;
    end
    else if (core.tmr_done)
    begin
      abort_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      abort_r <= wdat[nva_pkg::B_ABORT];
    end
  end

  // Done flag: completion wins over a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      done_r <= 1'b0;
    end
    else if (core.tmr_done)
    begin
      done_r <= 1'b1;
    end
    else if (flag_wr && !wdat[nva_pkg::B_DONE])
    begin
      done_r <= 1'b0;
    end
  end

  // Two-cycle fetch (array read, then value load); the read is refused for flash or configuration space
  always_ff @(posedge clk)
  begin
    if (!resetn || warm_reset)
    begin
      fetch_r      <= 1'b0;
      fetch_load_r <= 1'b0;
    end
    else
    begin
      fetch_r      <= ctrl_wr && wdat[nva_pkg::B_FETCH] && !space_nxt && !cfg_nxt;
      fetch_load_r <= fetch_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      index_r <= nva_pkg::RESET_BYTE;
    end
    else if (index_wr)
    begin
      index_r <= wdat;
    end
  end

  // Fetched byte stays until the next fetch or a software write
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      value_r <= nva_pkg::RESET_BYTE;
    end
    else if (value_wr)
    begin
      value_r <= wdat;
    end
    else if (fetch_load_r)
    begin
      value_r <= core.mem_rdata;
    end
  end

  // Transfer size is not checked: only whole words are supported
  logic unused_size;
  assign unused_size = ^hsize;
endmodule : nva_access

// File: logic/nva_pkg.sv
// Constants and types shared by the nonvolatile data array access block
package nva_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_INDEX  = 8'h08;
  localparam logic [7:0] OFS_VALUE  = 8'h0C;
  localparam logic [7:0] OFS_FLAG   = 8'h10;

  // Field positions in nv_control_one
  localparam int B_SPACE  = 7;
  localparam int B_CFG    = 6;
  localparam int B_ROW    = 4;
  localparam int B_ABORT  = 3;
  localparam int B_PERMIT = 2;
  localparam int B_CYCLE  = 1;
  localparam int B_FETCH  = 0;
  // Field position in peripheral_flag_reg
  localparam int B_DONE   = 4;

  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  // Self-timed write length
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WRITE_NS    = 4000000;
  localparam int WRITE_CYCLES  = T_WRITE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {UNL_IDLE, UNL_HALF, UNL_ARMED} nva_unlock_t;
  typedef enum logic [1:0] {TMR_IDLE, TMR_ERASE, TMR_PROG} nva_tmr_state_t;

endpackage : nva_pkg

// File: logic/nva_core_if.sv
// Carrier between the access controller, its array and its cycle timer
`timescale 1ns/1ps
interface nva_core_if;
  logic       mem_we;
  logic       mem_re;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic       tmr_start;
  logic       tmr_cancel;
  logic       tmr_busy;
  logic       tmr_erase_end;
  logic       tmr_done;

  modport ctl (
    output mem_we, mem_re, mem_addr, mem_wdata, tmr_start, tmr_cancel,
    input  mem_rdata, tmr_busy, tmr_erase_end, tmr_done
  );
  modport mem (
    input  mem_we, mem_re, mem_addr, mem_wdata,
    output mem_rdata
  );
  modport tmr (
    input  tmr_start, tmr_cancel,
    output tmr_busy, tmr_erase_end, tmr_done
  );
endinterface : nva_core_if

// File: logic/nva_array.sv
// 256-byte data array with registered read port
`timescale 1ns/1ps
module nva_array (
  input wire logic clk,
  nva_core_if.mem  port
);
  logic [7:0] cells [0:255];
  logic [7:0] rdata_r;

  // Contents are nonvolatile, so nothing here is reset
  always_ff @(posedge clk)
  begin
    if (port.mem_we)
    begin
      cells[port.mem_addr] <= port.mem_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (port.mem_re)
    begin
      rdata_r <= cells[port.mem_addr];
    end
  end

  assign port.mem_rdata = rdata_r;
endmodule : nva_array

// File: logic/nva_timer.sv
// Self-timed erase then program sequencer
`timescale 1ns/1ps
module nva_timer #(
  parameter int WRITE_CYCLES = nva_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  nva_core_if.tmr  tc
);
  localparam logic [31:0] ERASE_LEN = 32'(WRITE_CYCLES / 2);
  localparam logic [31:0] PROG_LEN  = 32'(WRITE_CYCLES - (WRITE_CYCLES / 2));
  localparam logic [31:0] ONE       = 32'h00000001;
  localparam logic [31:0] ZERO      = 32'h00000000;

  nva_pkg::nva_tmr_state_t state_r;
  logic [31:0]             count_r;

  always_ff @(posedge clk)
  begin
    if (!resetn || tc.tmr_cancel)
    begin
      state_r <= nva_pkg::TMR_IDLE;
      count_r <= ZERO;
    end
    else
    begin
      unique case (state_r)
        nva_pkg::TMR_IDLE:
        begin
          if (tc.tmr_start)
          begin
            state_r <= nva_pkg::TMR_ERASE;
            count_r <= ERASE_LEN - ONE;
          end
        end
        nva_pkg::TMR_ERASE:
        begin
          if (count_r == ZERO)
          begin
            state_r <= nva_pkg::TMR_PROG;
            count_r <= PROG_LEN - ONE;
          end
          else
          begin
            count_r <= count_r - ONE;
          end
        end
        nva_pkg::TMR_PROG:
        begin
          if (count_r == ZERO)
          begin
            state_r <= nva_pkg::TMR_IDLE;
          end
          else
          begin
            count_r <= count_r - ONE;
          end
        end
        default:
        begin
          state_r <= nva_pkg::TMR_IDLE;
        end
      endcase
    end
  end

  assign tc.tmr_busy      = (state_r != nva_pkg::TMR_IDLE);
  assign tc.tmr_erase_end = (state_r == nva_pkg::TMR_ERASE) && (count_r == ZERO);
  assign tc.tmr_done      = (state_r == nva_pkg::TMR_PROG) && (count_r == ZERO);
endmodule : nva_timer

// File: verification/nva_access_chk.sv
// Bus-level checker for the nonvolatile access block
`timescale 1ns/1ps
module nva_access_chk (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  logic       rd_r;
  logic       wr_r;
  logic       dn_r;
  logic       pw_r;
  logic [7:0] ad_r;
  wire        acc = hsel & hready & htrans[1];
  wire        fin = rd_r & hreadyout;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk)
  begin
    if (!resetn)
      {rd_r, wr_r} <= 2'b00;
    else if (hreadyout)
      {rd_r, wr_r} <= {acc & !hwrite, acc & hwrite};
  end
  always_ff @(posedge clk)
  begin
    if (acc)
      ad_r <= haddr[7:0];
  end
  // Done seen set stays set until software writes the flag register
  always_ff @(posedge clk)
  begin
    if (!resetn)
      dn_r <= 1'b0;
    else if (wr_r && ad_r == nva_pkg::OFS_FLAG)
      dn_r <= 1'b0;
    else if (fin && ad_r == nva_pkg::OFS_FLAG)
      dn_r <= hrdata[nva_pkg::B_DONE];
  end
  always_ff @(posedge clk)
  begin
    if (!resetn)
      pw_r <= 1'b0;
    else if (wr_r && ad_r == nva_pkg::OFS_CTRL)
      pw_r <= 1'b1;
  end
  sequence s_rd;
    acc && !hwrite;
  endsequence
  sequence s_wait;
    !hreadyout ##[1:3] hreadyout;
  endsequence
  property p_rd_wait;
    s_rd |=> s_wait;
  endproperty
  property p_wr_fast;
    acc && hwrite |=> hreadyout;
  endproperty
  property p_width;
    fin |-> hrdata[31:8] == 24'h0 && !hresp;
  endproperty
  property p_unl;
    fin && ad_r == nva_pkg::OFS_UNLOCK |-> hrdata == 32'h0;
  endproperty
  property p_bit5;
    fin && ad_r == nva_pkg::OFS_CTRL |-> !hrdata[5];
  endproperty
  property p_done_hold;
    fin && ad_r == nva_pkg::OFS_FLAG && dn_r |-> hrdata[nva_pkg::B_DONE];
  endproperty
  property p_hold;
    $changed(hrdata) |-> $past(rd_r);
  endproperty
  property p_perm;
    fin && ad_r == nva_pkg::OFS_CTRL && !pw_r |-> !hrdata[nva_pkg::B_PERMIT];
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait shape wrong");
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  a_width: assert property (p_width) else $error("read word not byte wide");
  a_unl: assert property (p_unl) else $error("unlock port read nonzero");
  a_bit5: assert property (p_bit5) else $error("control bit 5 set");
  a_done_hold: assert property (p_done_hold) else $error("done flag lost");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_perm: assert property (p_perm) else $error("permit set at power-up");
endmodule : nva_access_chk

// File: verification/nva_access_tb.sv
// Self-checking bench for the nonvolatile access block
`timescale 1ns/1ps
module nva_access_tb;
  localparam int         WC = 8;
  localparam logic [7:0] ACT = nva_pkg::OFS_CTRL;
  localparam logic [7:0] AUN = nva_pkg::OFS_UNLOCK;
  localparam logic [7:0] AIX = nva_pkg::OFS_INDEX;
  localparam logic [7:0] AVL = nva_pkg::OFS_VALUE;
  localparam logic [7:0] AFL = nva_pkg::OFS_FLAG;
  logic        clk;
  logic        resetn;
  logic        warm_reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [7:0]  ix;
  logic [7:0]  vl;
  logic [7:0]  c;
  int          num_errors;
  int          check_count;

  nva_access #(.WRITE_CYCLES(WC)) u_dut (
    .clk        (clk),
    .resetn     (resetn),
    .warm_reset (warm_reset),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (3'h2),
    .hwdata     (hwdata),
    .hready     (hreadyout),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .hrdata     (hrdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read right at the edge: design state only moves in the NBA region after it
  task automatic wait_rdy;
    do
    begin
      @(posedge clk);
    end
    while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= nva_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic store(input logic [7:0] i, input logic [7:0] v, input logic [7:0] k);
    wr(AIX, i);
    wr(AVL, v);
    wr(ACT, 8'h04);
    wr(AUN, nva_pkg::KEY_FIRST);
    wr(AUN, nva_pkg::KEY_SECOND);
    wr(ACT, k);
  endtask : store

  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      rd(ACT);
      n++;
    end
    while (r[1] === 1'b1 && n < 4 * WC);
  endtask : wait_done

  task automatic fetch(input logic [7:0] i);
    wr(AIX, i);
    wr(ACT, 8'h01);
    rd(AVL);
  endtask : fetch

  // Selects and permit survive a cycle; row erase and launch do not
  function automatic logic [31:0] after_cycle(input logic [7:0] k);
    return {24'h0, k & 8'hC4};
  endfunction : after_cycle

  initial
  begin
    #500000;
    num_errors++;
    close_out();
  end

  initial
  begin
    {hsel, hwrite, warm_reset, resetn} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    num_errors = 0;
    check_count = 0;
    r = $urandom(20);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(ACT);
    chk(r, 32'h0);
    rd(AUN);
    chk(r, 32'h0);
    rd(AFL);
    chk(r, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 4; k++)
    begin
      ix = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
      vl = 8'($urandom);
      store(ix, vl, 8'h06);
      rd(ACT);
      chk(r, 32'h06);
      repeat (WC - 6) @(posedge clk);
      rd(ACT);
      chk(r, 32'h06);
      rd(ACT);
      chk(r, 32'h04);
      wait_done();
      chk(r, 32'h04);
      rd(AFL);
      rd(AFL);
      chk(r, 32'h10);
      wr(AFL, 8'h00);
      rd(AFL);
      chk(r, 32'h0);
      fetch(ix);
      chk(r, {24'h0, vl});
      rd(ACT);
      chk(r, 32'h0);
    end
    $display("store and fetch test done");
    store(ix, ~vl, 8'h06);
    wr(AIX, ~ix);
    wr(AVL, vl);
    wr(ACT, 8'h80);
    wait_done();
    chk(r, 32'h04);
    rd(AIX);
    chk(r, {24'h0, ix});
    fetch(ix);
    vl = ~vl;
    chk(r, {24'h0, vl});
    $display("busy lockout test done");
    wr(ACT, 8'h04);
    wr(AUN, nva_pkg::KEY_SECOND);
    wr(AUN, nva_pkg::KEY_FIRST);
    wr(ACT, 8'h06);
    rd(ACT);
    chk(r, 32'h0C);
    wr(ACT, 8'h00);
    wr(AUN, nva_pkg::KEY_FIRST);
    wr(AUN, nva_pkg::KEY_SECOND);
    wr(ACT, 8'h06);
    rd(ACT);
    chk(r & 32'h0A, 32'h08);
    fetch(ix);
    chk(r, {24'h0, vl});
    $display("unlock order test done");
    wr(AVL, ~vl);
    for (int j = 0; j < 2; j++)
    begin
      c = (j != 0) ? 8'h41 : 8'h81;
      wr(ACT, c);
      rd(AVL);
      chk(r, {24'h0, ~vl});
    end
    for (int j = 0; j < 3; j++)
    begin
      c = (j == 0) ? 8'h86 : (j == 1) ? 8'h46 : 8'h16;
      store(ix, ~vl, c);
      wait_done();
      chk(r, after_cycle(c));
      fetch(ix);
      chk(r, {24'h0, vl});
    end
    $display("space select test done");
    store(ix, ~vl, 8'h86);
    @(posedge clk);
    warm_reset <= 1'b1;
    @(posedge clk);
    warm_reset <= 1'b0;
    rd(ACT);
    chk(r & 32'h8A, 32'h88);
    wr(ACT, 8'h24);
    rd(ACT);
    chk(r, 32'h04);
    wr(8'h20, 8'hFF);
    rd(8'h20);
    chk(r, 32'h0);
    $display("abort and map test done");
    close_out();
  end
endmodule : nva_access_tb

bind nva_access nva_access_chk u_chk (
  .clk       (clk),
  .resetn    (resetn),
  .hsel      (hsel),
  .haddr     (haddr),
  .htrans    (htrans),
  .hwrite    (hwrite),
  .hready    (hready),
  .hreadyout (hreadyout),
  .hresp     (hresp),
  .hrdata    (hrdata)
);
